// [core/etc_pkg.sv]
package etc_pkg;
    // ------------------------------------------------------------
    // register byte addresses on the axi4-lite bus
    // ------------------------------------------------------------
    localparam logic [3:0] ADDR_CONTROL = 4'h0;  // counter_control
    localparam logic [3:0] ADDR_LOW = 4'h4;      // count_low_byte
    localparam logic [3:0] ADDR_HIGH = 4'h8;     // count_high_buffer
    localparam logic [3:0] ADDR_INTCTL = 4'hC;   // interrupt_control

    // ------------------------------------------------------------
    // counter_control field positions and reset value
    // ------------------------------------------------------------
    localparam int BIT_RUN = 7;
    localparam int BIT_WIDTH8 = 6;
    localparam int BIT_SOURCE = 5;
    localparam int BIT_EDGE = 4;
    localparam int BIT_BYPASS = 3;
    localparam int RATIO_MSB = 2;
    localparam logic [7:0] CONTROL_RESET = 8'hFF;

    // ------------------------------------------------------------
    // interrupt_control field positions; interrupt_control, count_high_buffer and count_low reset values
    // ------------------------------------------------------------
    localparam int BIT_IRQ_EN = 5;
    localparam int BIT_OVF_FLAG = 2;
    localparam logic [7:0] INTCTL_RESET = 8'h00;
    localparam logic [7:0] HIGH_RESET = 8'h00;
    localparam logic [7:0] LOW_RESET = 8'h00;

    // ------------------------------------------------------------
    // timing: instruction cycle is four system clocks
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 10;
    localparam int INSTR_PERIOD_NS = 40;
    localparam int INSTR_CYCLES = (INSTR_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int INHIBIT_INSTR = 2;
    localparam int PHASE_WIDTH = 2;

    // axi response codes
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// [core/etc_sync.sv]
// ------------------------------------------------------------
// three-stage pin synchroniser with agreement filter
// ------------------------------------------------------------
module etc_sync (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic clk_en,
    input wire logic pin_in,
    output logic pin_level
);
    logic stage1;  // metastable stage, read only by stage2
    logic stage2;
    logic stage3;

    // shift chain; level moves only when the two settled stages agree
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            stage1 <= 1'b0;
            stage2 <= 1'b0;
            stage3 <= 1'b0;
            pin_level <= 1'b0;
        end else if (clk_en) begin
            stage1 <= pin_in;
            stage2 <= stage1;
            stage3 <= stage2;
            if (stage2 == stage3) begin
                pin_level <= stage3;
            end
        end
    end
endmodule

// [core/etc_timer.sv]
module etc_timer (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic clk_en,
    input wire logic sleep,
    input wire logic external_count_pin,
    output logic overflow_irq,
    input wire logic [31:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [31:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    localparam int PHASE_WIDTH_L = etc_pkg::PHASE_WIDTH;
    localparam logic [PHASE_WIDTH_L-1:0] PHASE_LAST =
        PHASE_WIDTH_L'(etc_pkg::INSTR_CYCLES - 1);
    localparam logic [1:0] INHIBIT_LOAD = 2'(etc_pkg::INHIBIT_INSTR);

    logic [7:0] counter_control;      // mode bits
    logic [7:0] interrupt_control;    // enable and flag
    logic [7:0] count_high_buffer;    // software-visible buffer
    logic [7:0] count_low;            // true low byte
    logic [7:0] count_upper;          // true upper byte, hidden
    logic [7:0] divider;              // hidden prescaler count
    logic [PHASE_WIDTH_L-1:0] phase;  // system clocks within a cycle
    logic [1:0] inhibit;              // instruction cycles still held
    logic pin_level;                  // synchronised pin
    logic pin_prev;                   // previous synchronised level

    // ------------------------------------------------------------
    // axi write channel: take address and data in either order
    // ------------------------------------------------------------
    logic aw_held;
    logic aw_out;  // address above the register window
    logic w_held;
    logic [3:0] aw_addr;
    logic [7:0] w_byte;
    logic w_lane0;
    logic do_write;
    logic wr_ok;

    assign s_axi_awready = !aw_held && !s_axi_bvalid;
    assign s_axi_wready = !w_held && !s_axi_bvalid;
    assign do_write = aw_held && w_held && clk_en;
    // upper address bits must be zero, or the four registers would alias
    assign wr_ok = !aw_out && ((aw_addr == etc_pkg::ADDR_CONTROL)
        || (aw_addr == etc_pkg::ADDR_LOW) || (aw_addr == etc_pkg::ADDR_HIGH)
        || (aw_addr == etc_pkg::ADDR_INTCTL));

    // capture write address and data, then answer
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= 4'h0;
            aw_out <= 1'b0;
            w_byte <= 8'h00;
            w_lane0 <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= etc_pkg::RESP_OKAY;
        end else if (clk_en) begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr[3:0];
                aw_out <= s_axi_awaddr[31:4] != 28'h0000000;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held <= 1'b1;
                w_byte <= s_axi_wdata[7:0];
                w_lane0 <= s_axi_wstrb[0];
            end
            if (do_write) begin
                aw_held <= 1'b0;
                w_held <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_ok ? etc_pkg::RESP_OKAY : etc_pkg::RESP_SLVERR;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // register write strobes, only lane 0 carries data
    logic wr_control;
    logic wr_low;
    logic wr_high;
    logic wr_intctl;
    assign wr_control = do_write && w_lane0 && !aw_out && aw_addr == etc_pkg::ADDR_CONTROL;
    assign wr_low = do_write && w_lane0 && !aw_out && aw_addr == etc_pkg::ADDR_LOW;
    assign wr_high = do_write && w_lane0 && !aw_out && aw_addr == etc_pkg::ADDR_HIGH;
    assign wr_intctl = do_write && w_lane0 && !aw_out && aw_addr == etc_pkg::ADDR_INTCTL;

    // ------------------------------------------------------------
    // axi read channel: one-cycle answer from registers
    // ------------------------------------------------------------
    logic rd_low;
    logic ar_out;  // read address above the register window
    assign s_axi_arready = !s_axi_rvalid;
    assign ar_out = s_axi_araddr[31:4] != 28'h0000000;
    assign rd_low = s_axi_arvalid && s_axi_arready && clk_en && !ar_out
        && s_axi_araddr[3:0] == etc_pkg::ADDR_LOW;

    // read mux and response
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= etc_pkg::RESP_OKAY;
        end else if (clk_en) begin
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp <= etc_pkg::RESP_OKAY;
                case ({ar_out, s_axi_araddr[3:0]})
                    {1'b0, etc_pkg::ADDR_CONTROL}: s_axi_rdata <= {24'h000000, counter_control};
                    {1'b0, etc_pkg::ADDR_LOW}: s_axi_rdata <= {24'h000000, count_low};
                    {1'b0, etc_pkg::ADDR_HIGH}: s_axi_rdata <= {24'h000000, count_high_buffer};
                    {1'b0, etc_pkg::ADDR_INTCTL}: s_axi_rdata <= {24'h000000, interrupt_control};
                    default: begin
                        s_axi_rdata <= 32'h0000_0000;
                        s_axi_rresp <= etc_pkg::RESP_SLVERR;
                    end
                endcase
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // count source
    // ------------------------------------------------------------
    // pin synchroniser
    etc_sync u_sync (
        .aclk(aclk),
        .aresetn(aresetn),
        .clk_en(clk_en),
        .pin_in(external_count_pin),
        .pin_level(pin_level)
    );

    // edge detector and instruction phase counter
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pin_prev <= 1'b0;
            phase <= '0;
        end else if (clk_en) begin
            pin_prev <= pin_level;
            phase <= (phase == PHASE_LAST) ? '0 : phase + 1'b1;
        end
    end

    logic instr_tick;   // one system clock per instruction cycle
    logic pin_edge;     // selected pin transition
    logic source_tick;  // raw count event
    logic div_tick;     // divider output event
    logic count_tick;   // event reaching the counter
    logic running;
    assign instr_tick = phase == PHASE_LAST;
    // falling when edge bit set, rising otherwise
    assign pin_edge = counter_control[etc_pkg::BIT_EDGE] ? (pin_prev && !pin_level)
        : (!pin_prev && pin_level);
    assign source_tick = counter_control[etc_pkg::BIT_SOURCE] ? pin_edge : instr_tick;
    assign running = counter_control[etc_pkg::BIT_RUN] && !sleep;

    // ------------------------------------------------------------
    // prescaler
    // ------------------------------------------------------------
    logic [2:0] ratio;
    logic [7:0] div_mask;
    assign ratio = counter_control[etc_pkg::RATIO_MSB:0];
    assign div_mask = 8'((9'h002 << ratio) - 9'h001);
    assign div_tick = source_tick && ((divider & div_mask) == div_mask);
    // bypass picks the raw source; read live each cycle
    assign count_tick = counter_control[etc_pkg::BIT_BYPASS] ? source_tick : div_tick;

    // hidden divider count, no bus path
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            divider <= 8'h00;
        end else if (clk_en) begin
            if (wr_low && !counter_control[etc_pkg::BIT_BYPASS]) begin
                divider <= 8'h00;
            end else if (running && source_tick && !counter_control[etc_pkg::BIT_BYPASS]) begin
                divider <= divider + 8'h01;
            end
        end
    end

    // ------------------------------------------------------------
    // counter core
    // ------------------------------------------------------------
    logic step;
    logic wrap;
    logic width8;
    assign width8 = counter_control[etc_pkg::BIT_WIDTH8];
    // step blocked while inhibit is live
    assign step = running && count_tick && inhibit == 2'd0;
    // rollover, low byte only in 8-bit mode
    assign wrap = step && count_low == 8'hFF && (width8 || count_upper == 8'hFF);

    // inhibit counts instruction cycles after a count write
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            inhibit <= 2'd0;
        end else if (clk_en) begin
            if (wr_low) begin
                inhibit <= INHIBIT_LOAD;
            end else if (instr_tick && inhibit != 2'd0) begin
                inhibit <= inhibit - 2'd1;
            end
        end
    end

    // count bytes; prescaler bypassed steps each source tick
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            count_low <= etc_pkg::LOW_RESET;
            count_upper <= 8'h00;
        end else if (clk_en) begin
            if (wr_low) begin
                count_low <= w_byte;
                if (!width8) begin
                    count_upper <= count_high_buffer;
                end
            end else if (step) begin
                count_low <= count_low + 8'h01;
                // upper carries only in 16-bit mode
                if (!width8 && count_low == 8'hFF) begin
                    count_upper <= count_upper + 8'h01;
                end
            end
        end
    end

    // in 16-bit mode a low read snapshots the upper byte; buffer write stands alone
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            count_high_buffer <= etc_pkg::HIGH_RESET;
        end else if (clk_en) begin
            if (wr_high) begin
                count_high_buffer <= w_byte;
            end else if (rd_low && !width8) begin
                count_high_buffer <= count_upper;
            end
        end
    end

    // ------------------------------------------------------------
    // control and interrupt registers
    // ------------------------------------------------------------
    // width and mode bits written whole
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            counter_control <= etc_pkg::CONTROL_RESET;
        end else if (clk_en && wr_control) begin
            counter_control <= w_byte;
        end
    end

    // flag set wins over a same-cycle clear; never self-clears
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            interrupt_control <= etc_pkg::INTCTL_RESET;
        end else if (clk_en) begin
            if (wr_intctl) begin
                interrupt_control <= w_byte;
            end
            if (wrap) begin
                interrupt_control[etc_pkg::BIT_OVF_FLAG] <= 1'b1;
            end
        end
    end

    assign overflow_irq = interrupt_control[etc_pkg::BIT_IRQ_EN]
        && interrupt_control[etc_pkg::BIT_OVF_FLAG];

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    chk_wrap_sets_flag: assert property (clk_en && wrap |=> interrupt_control[2])
        else $error("overflow did not set flag");
    chk_irq_masked: assert property (!interrupt_control[5] |-> !overflow_irq)
        else $error("irq not masked");
    chk_stop_holds: assert property (!running && !wr_low |=> $stable(count_low))
        else $error("count moved while halted");
    chk_sleep_flag: assert property (sleep && !wr_intctl && !interrupt_control[2]
        |=> !interrupt_control[2])
        else $error("overflow during sleep");
    chk_inhibit_load: assert property (wr_low |=> inhibit == 2'd2)
        else $error("inhibit not armed");
    chk_inhibit_hold: assert property (inhibit != 2'd0 && !wr_low |=> $stable(count_low))
        else $error("count moved while inhibited");
    chk_low_snapshot: assert property (rd_low && !width8 && !wr_high
        |=> count_high_buffer == $past(count_upper))
        else $error("high buffer not snapshotted");
    chk_low_load: assert property (wr_low && !width8
        |=> count_upper == $past(count_high_buffer))
        else $error("upper byte not loaded");
    chk_divider_clear: assert property (wr_low && !counter_control[3]
        |=> divider == 8'h00)
        else $error("divider not cleared");
    chk_width8_upper: assert property (width8 && !wr_low |=> $stable(count_upper))
        else $error("upper moved in 8-bit mode");

    cov_overflow: cover property (wrap);
    cov_pin_count: cover property (step && counter_control[5]);
    cov_divided: cover property (step && !counter_control[3]);
    cov_snapshot: cover property (rd_low && !width8);
endmodule

// [sim/etc_pin_src.sv]
module etc_pin_src (
    input wire logic aclk,
    output logic pin
);
    timeunit 1ns;
    timeprecision 1ps;

    // ------------------------------------------------------------
    // external count source, idle level held between bursts
    // ------------------------------------------------------------
    initial begin
        pin = 1'b0;
    end

    task automatic toggle(input int n, input int gap);
        repeat (n) begin
            @(posedge aclk);
            pin <= ~pin;
            // a short gap answers promptly, a long one slowly
            repeat (gap) @(posedge aclk);
        end
    endtask
endmodule

// [sim/etc_timer_test.sv]
module etc_timer_test;
    timeunit 1ns;
    timeprecision 1ps;

    // ------------------------------------------------------------
    // wires, expectation queue and counters
    // ------------------------------------------------------------
    typedef struct {bit rd; logic [31:0] a; logic [1:0] resp;
                    logic [31:0] lo; logic [31:0] hi;} etc_note_t;
    localparam logic [31:0] A_CTL = {28'h0, etc_pkg::ADDR_CONTROL};
    localparam logic [31:0] A_LO = {28'h0, etc_pkg::ADDR_LOW};
    localparam logic [31:0] A_HI = {28'h0, etc_pkg::ADDR_HIGH};
    localparam logic [31:0] A_INT = {28'h0, etc_pkg::ADDR_INTCTL};
    localparam logic [1:0] OK = etc_pkg::RESP_OKAY;
    localparam int LIMIT = 60000; // prescaler sweep dominates the run
    logic aclk, aresetn, clk_en, sleep, pin, overflow_irq;
    logic [31:0] awaddr, wdata, araddr, rdata;
    logic [3:0] wstrb;
    logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
    logic [1:0] bresp, rresp;
    etc_note_t q[$];
    etc_note_t e;
    logic ok;
    int n_mismatch, num_checks, cyc, t_b, t0, seed, i, x;

    etc_timer i_dut (.aclk(aclk), .aresetn(aresetn), .clk_en(clk_en), .sleep(sleep),
        .external_count_pin(pin), .overflow_irq(overflow_irq),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
    etc_pin_src i_pin (.aclk(aclk), .pin(pin));

    initial begin
        aclk = 1'b0;
        forever #5 aclk = ~aclk;
    end

    // ------------------------------------------------------------
    // bus master tasks; each notes its expected answer first
    // ------------------------------------------------------------
    task automatic wr(input logic [31:0] a, input logic [7:0] d, input logic [1:0] r);
        bit aw_ok, w_ok;
        q.push_back('{1'b0, a, r, 32'h0, 32'h0});
        awaddr <= a;
        wdata <= {24'h0, d};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        aw_ok = 0;
        w_ok = 0;
        // address and data may be taken in either order
        while (!(aw_ok && w_ok)) begin
            @(posedge aclk);
            if (awvalid && awready) begin
                aw_ok = 1;
                awvalid <= 1'b0;
            end
            if (wvalid && wready) begin
                w_ok = 1;
                wvalid <= 1'b0;
            end
        end
        do @(posedge aclk); while (!bvalid);
        // bready stays high, so a next call never lowers and raises it in one step
        t_b = cyc;
    endtask

    task automatic rd(input logic [31:0] a, input logic [31:0] lo, input logic [31:0] hi,
                      input logic [1:0] r);
        q.push_back('{1'b1, a, r, lo, hi});
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(posedge aclk); while (!arready);
        arvalid <= 1'b0;
        do @(posedge aclk); while (!rvalid);
    endtask

    // irq is combinational from registers, so look after they settle
    task automatic irq_is(input logic v);
        #1;
        num_checks++;
        if (overflow_irq !== v) begin
            n_mismatch++;
            $display("[FAIL] overflow_irq expected %b seen %b", v, overflow_irq);
        end
    endtask

    // load while stopped, run for a span, stop, then read the low byte
    task automatic run_chk(input logic [7:0] ctl, input logic [7:0] hb, input logic [7:0] lb,
                           input int n, input int div);
        int c0, ev, tol;
        logic [7:0] xv;
        wr(A_CTL, ctl & 8'h7F, OK);
        wr(A_HI, hb, OK);
        wr(A_LO, lb, OK);
        // let the post-write hold run out before starting
        repeat (20) @(posedge aclk);
        ev = (ctl[4] == pin) ? (n + 1) / 2 : n / 2;
        wr(A_CTL, ctl, OK);
        c0 = t_b;
        if (ctl[5]) begin
            i_pin.toggle(n, 8 + 4 * n);
        end else begin
            repeat (n) @(posedge aclk);
        end
        wr(A_CTL, ctl & 8'h7F, OK);
        if (!ctl[5]) ev = (t_b - c0) / (etc_pkg::INSTR_CYCLES * div);
        if (sleep) ev = 0;
        // the instruction phase leaves one count of slack on timed spans
        tol = (ctl[5] || sleep) ? 0 : 1;
        xv = lb + ev[7:0];
        rd(A_LO, 32'(xv) - 32'(tol), 32'(xv) + 32'(tol), OK);
    endtask

    task automatic final_report();
        if (n_mismatch == 0 && num_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // ------------------------------------------------------------
    // monitor: each response takes the oldest note
    // ------------------------------------------------------------
    always @(posedge aclk) begin
        cyc <= cyc + 1;
        if (cyc == LIMIT) begin
            n_mismatch++;
            final_report();
        end
        if ((bvalid && bready) || (rvalid && rready)) begin
            e = q.pop_front();
            num_checks++;
            ok = e.rd ? (rresp === e.resp && rdata >= e.lo && rdata <= e.hi) : (bresp === e.resp);
            if (ok !== 1'b1) begin
                n_mismatch++;
                $display("[FAIL] addr %h expected %h..%h resp %h seen %h resp %h", e.a, e.lo,
                         e.hi, e.resp, e.rd ? rdata : 32'h0, e.rd ? rresp : bresp);
            end
        end
    end

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        {aresetn, sleep, awvalid, wvalid, bready, arvalid, rready} = '0;
        {awaddr, wdata, araddr} = '0;
        clk_en = 1'b1;
        wstrb = 4'hF;
        seed = 44;
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        rd(A_CTL, 32'hFF, 32'hFF, OK);
        rd(A_INT, 32'h0, 32'h0, OK);
        rd(A_HI, 32'h0, 32'h0, OK);
        rd(A_LO, 32'h0, 32'h0, OK);
        rd(32'h10, 32'h0, 32'h0, etc_pkg::RESP_SLVERR);
        wr(32'h10, 8'h5A, etc_pkg::RESP_SLVERR);
        // buffered 16-bit transfer while stopped
        wr(A_CTL, 8'h08, OK);
        wr(A_HI, 8'h12, OK);
        wr(A_LO, 8'h34, OK);
        wr(A_HI, 8'h56, OK);
        rd(A_LO, 32'h34, 32'h34, OK);
        rd(A_HI, 32'h12, 32'h12, OK);
        // every divider ratio, random base and span
        for (i = 0; i < 8; i++) begin
            x = $random(seed);
            run_chk(8'hC0 | 8'(i), 8'h00, 8'(x) & 8'h7F, 48 * (1 << i) + (x[11:8] & 4'hF),
                    2 << i);
        end
        // 8-bit rollover with the request enabled
        wr(A_INT, 8'h20, OK);
        run_chk(8'hC8, 8'h77, 8'hFC, 29, 1);
        rd(A_HI, 32'h77, 32'h77, OK);
        irq_is(1'b1);
        rd(A_INT, 32'h24, 32'h24, OK);
        wr(A_INT, 8'h04, OK);
        irq_is(1'b0);
        wr(A_INT, 8'h00, OK);
        rd(A_INT, 32'h0, 32'h0, OK);
        // 16-bit rollover, low read snapshots the upper byte
        run_chk(8'h88, 8'hFF, 8'hFC, 29, 1);
        rd(A_HI, 32'h0, 32'h0, OK);
        rd(A_INT, 32'h04, 32'h04, OK);
        irq_is(1'b0);
        // count write while running holds two increments
        wr(A_CTL, 8'hC8, OK);
        wr(A_LO, 8'h10, OK);
        t0 = t_b;
        repeat (40) @(posedge aclk);
        wr(A_CTL, 8'h48, OK);
        x = 16 + (t_b - t0) / etc_pkg::INSTR_CYCLES - etc_pkg::INHIBIT_INSTR;
        rd(A_LO, 32'(x - 1), 32'(x + 1), OK);
        // pin counting, rising then falling edges
        run_chk(8'hE8, 8'h00, 8'h00, 5, 1);
        run_chk(8'hF8, 8'h00, 8'h00, 5, 1);
        // asleep: nothing counts
        sleep <= 1'b1;
        run_chk(8'hC8, 8'h00, 8'h20, 40, 1);
        sleep <= 1'b0;
        final_report();
    end
endmodule
